// File: core/sfc_fifo.sv
// FIFO store with status flags, depth cascade and AXI4-Lite registers.
// Assumes producer and consumer share aclk; straps and cascade inputs
// are pins and pass a two-flop synchroniser.
`default_nettype none

module sfc_fifo #(
  parameter int unsigned DEPTH  = sfc_pkg::DEPTH_DEF,
  parameter int unsigned DATA_W = sfc_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Producer
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wr_data,
  // Consumer
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] read_data_bus,
  // Straps and cascade inputs
  input  wire logic              first_load_strap,
  input  wire logic              write_cascade_in,
  input  wire logic              read_cascade_in,
  // Flags and cascade outputs
  output logic                   full_flag_n,
  output logic                   empty_flag_n,
  output logic                   almost_empty_n,
  output logic                   almost_full_n,
  output logic                   half_full_n,
  output logic                   read_cascade_out,
  output logic                   irq,
  // AXI4-Lite slave
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned LW = AW + 2;
  localparam logic [1:0] FT_LAST = 2'(sfc_pkg::FT_EDGES - 1);

  if (DEPTH < 256 || DEPTH > 4096 || (1 << AW) != DEPTH || DATA_W != 18) begin : g_bad
    $error("sfc_fifo: DEPTH must be a power of two 256..4096, DATA_W 18");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= sfc_pkg::ADDR_IRQ_EN;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_s1, pin_s2;
  logic [1:0] casc_prev;

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    pin_s1 <= {first_load_strap, write_cascade_in, read_cascade_in};
    pin_s2 <= pin_s1;
  end

  // Third stage only for falling-edge detection of cascade pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) casc_prev <= 2'h3;
    else casc_prev <= pin_s2[1:0];
  end

  wire wxi_fall = casc_prev[1] & ~pin_s2[1];
  wire rxi_fall = casc_prev[0] & ~pin_s2[0];

  // ----------------------------------------------------------------
  // Mode and cascade tokens
  // ----------------------------------------------------------------
  logic                   strap_fall_through_mode_reg, strap_sync_reg, ctrl_cascade_reg;
  sfc_pkg::sfc_mode_t     mode;
  logic                   wr_tok, rd_tok;

  // Straps are caught while reset is held, not sampled live
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_fall_through_mode_reg <= pin_s2[2];
      strap_sync_reg <= pin_s2[1] & pin_s2[0];
    end
  end

  // Cascade forces standard timing; otherwise the straps decide
  always_comb begin
    mode.cascade     = ctrl_cascade_reg;
    mode.fall_through_mode        = !ctrl_cascade_reg && strap_fall_through_mode_reg;
    mode.sync_almost = strap_sync_reg;
  end

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [AW-1:0]     wr_ptr, rd_ptr;
  logic [AW:0]       cnt;
  logic              ov;
  logic [1:0]        ft_cnt;

  wire full   = cnt == (AW+1)'(DEPTH);
  wire wr_ok  = wr_en && !full && (!mode.cascade || wr_tok);
  wire std_rd = !mode.fall_through_mode && rd_en && cnt != '0
                && (!mode.cascade || rd_tok);
  wire pop    = mode.fall_through_mode && rd_en && ov;
  wire fetch  = mode.fall_through_mode && cnt != '0 && (pop || (!ov && ft_cnt == FT_LAST));
  wire mem_rd = std_rd || fetch;
  wire [AW:0] cnt_next = cnt + (AW+1)'(wr_ok) - (AW+1)'(mem_rd);
  wire last_wr = wr_ok && wr_ptr == AW'(DEPTH - 1);
  wire last_rd = mem_rd && rd_ptr == AW'(DEPTH - 1);

  // Array write; no reset, contents are don't-care until written
  always_ff @(posedge aclk) begin
    if (wr_ok) mem[wr_ptr] <= wr_data;
  end

  // Pointers and word count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt    <= '0;
    end else begin
      if (wr_ok) wr_ptr <= wr_ptr + AW'(1);
      if (mem_rd) rd_ptr <= rd_ptr + AW'(1);
      cnt <= cnt_next;
    end
  end

  // Output register; holds its word when no read is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_data_bus <= '0;
      ov            <= 1'h0;
      ft_cnt        <= 2'h0;
    end else begin
      if (mem_rd) read_data_bus <= mem[rd_ptr];
      if (fetch) ov <= 1'h1;
      else if (pop) ov <= 1'h0;
      // Word waiting in an empty output stage counts three edges
      if (mode.fall_through_mode && !ov && cnt != '0 && ft_cnt != FT_LAST)
        ft_cnt <= ft_cnt + 2'h1;
      else
        ft_cnt <= 2'h0;
    end
  end

  // Cascade tokens: the first device (strap low) starts as owner
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_tok <= !pin_s2[2];
      rd_tok <= !pin_s2[2];
    end else begin
      if (last_wr && mode.cascade) wr_tok <= 1'h0;
      else if (wxi_fall) wr_tok <= 1'h1;
      if (last_rd && mode.cascade) rd_tok <= 1'h0;
      else if (rxi_fall) rd_tok <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  logic [sfc_pkg::OFF_W-1:0] ae_off, af_off;
  sfc_pkg::sfc_flags_t       flags;
  logic                      ae_stage, af_stage, rco_reg;

  wire [LW-1:0] level = LW'(cnt) + LW'(ov);
  wire ae_raw = !(32'(level) <= 32'(ae_off));
  wire af_raw = !(32'(level) + 32'(af_off) >= DEPTH);

  // All flags are registered on aclk, the consumer's own clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags    <= sfc_pkg::FLAGS_RST;
      ae_stage <= 1'h0;
      af_stage <= 1'h1;
      rco_reg  <= 1'h1;
    end else begin
      flags.full_n  <= mode.fall_through_mode ? full : !full;
      flags.empty_n <= mode.fall_through_mode ? !ov : cnt != '0;
      // Synchronous almost flags take one extra stage
      ae_stage <= ae_raw;
      af_stage <= af_raw;
      flags.almost_empty_n <= mode.sync_almost ? ae_stage : ae_raw;
      flags.almost_full_n  <= mode.sync_almost ? af_stage : af_raw;
      // Shared pin: half-full alone, write pulse in a chain
      if (mode.cascade) flags.half_full_n <= !last_wr;
      else flags.half_full_n <= !(32'(level) > DEPTH / 2);
      rco_reg <= !(mode.cascade && last_rd);
    end
  end

  assign full_flag_n      = flags.full_n;
  assign empty_flag_n     = flags.empty_n;
  assign almost_empty_n   = flags.almost_empty_n;
  assign almost_full_n    = flags.almost_full_n;
  assign half_full_n      = flags.half_full_n;
  assign read_cascade_out = rco_reg;

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  logic [sfc_pkg::EV_W-1:0] ev, irq_sts, irq_en, irq_clr;

  always_comb begin
    ev = '0;
    ev[sfc_pkg::EV_FULL]      = !full && cnt_next == (AW+1)'(DEPTH);
    ev[sfc_pkg::EV_EMPTY]     = cnt != '0 && cnt_next == '0;
    ev[sfc_pkg::EV_WR_REFUSE] = wr_en && !wr_ok;
    ev[sfc_pkg::EV_RD_REFUSE] = rd_en && !(std_rd || pop);
  end

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts <= '0;
      irq     <= 1'h0;
    end else begin
      irq_sts <= (irq_sts & ~irq_clr) | ev;
      irq     <= |(irq_sts & irq_en);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic        aw_hold, w_hold;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  wire aw_take = awvalid && awready;
  wire w_take  = wvalid && wready;
  wire do_wr   = aw_hold && w_hold && !bvalid;

  // Address and data taken in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'h0;
      w_hold  <= 1'h0;
      awready <= 1'h0;
      wready  <= 1'h0;
      bvalid  <= 1'h0;
      bresp   <= sfc_pkg::RESP_OKAY;
    end else begin
      if (aw_take) aw_hold <= 1'h1;
      else if (do_wr) aw_hold <= 1'h0;
      if (w_take) w_hold <= 1'h1;
      else if (do_wr) w_hold <= 1'h0;
      awready <= !(aw_take || (aw_hold && !do_wr));
      wready  <= !(w_take || (w_hold && !do_wr));
      if (do_wr) begin
        bvalid <= 1'h1;
        bresp  <= mapped(aw_addr_reg) ? sfc_pkg::RESP_OKAY : sfc_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_take) aw_addr_reg <= awaddr;
    if (w_take) begin
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end
  end

  // Register stores; the clear register acts for one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_cascade_reg <= 1'h0;
      ae_off  <= sfc_pkg::default_offset(DEPTH);
      af_off  <= sfc_pkg::default_offset(DEPTH);
      irq_en  <= '0;
      irq_clr <= '0;
    end else begin
      irq_clr <= '0;
      if (do_wr) begin
        case (aw_addr_reg)
          sfc_pkg::ADDR_CTRL:
            ctrl_cascade_reg <= 1'(merge(32'(ctrl_cascade_reg), w_data_reg,
                                         w_strb_reg) >> sfc_pkg::CTRL_CASCADE);
          sfc_pkg::ADDR_AE_OFF:
            ae_off <= (sfc_pkg::OFF_W)'(merge(32'(ae_off), w_data_reg, w_strb_reg));
          sfc_pkg::ADDR_AF_OFF:
            af_off <= (sfc_pkg::OFF_W)'(merge(32'(af_off), w_data_reg, w_strb_reg));
          sfc_pkg::ADDR_IRQ_CLR:
            irq_clr <= (sfc_pkg::EV_W)'(merge('0, w_data_reg, w_strb_reg));
          sfc_pkg::ADDR_IRQ_EN:
            irq_en <= (sfc_pkg::EV_W)'(merge(32'(irq_en), w_data_reg, w_strb_reg));
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  wire ar_take = arvalid && arready;

  always_comb begin
    rd_mux = '0;
    case (araddr)
      sfc_pkg::ADDR_CTRL:    rd_mux = 32'(ctrl_cascade_reg) << sfc_pkg::CTRL_CASCADE;
      sfc_pkg::ADDR_STATUS:  rd_mux = 32'(flags)
                                      | (32'(mode) << sfc_pkg::STS_MODE_LSB)
                                      | (32'({rd_tok, wr_tok}) << sfc_pkg::STS_TOK_LSB);
      sfc_pkg::ADDR_LEVEL:   rd_mux = 32'(level);
      sfc_pkg::ADDR_AE_OFF:  rd_mux = 32'(ae_off);
      sfc_pkg::ADDR_AF_OFF:  rd_mux = 32'(af_off);
      sfc_pkg::ADDR_IRQ_STS: rd_mux = 32'(irq_sts);
      sfc_pkg::ADDR_IRQ_EN:  rd_mux = 32'(irq_en);
      default:               rd_mux = '0;
    endcase
  end

  // One read at a time; data registered with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'h0;
      rvalid  <= 1'h0;
      rdata   <= '0;
      rresp   <= sfc_pkg::RESP_OKAY;
    end else begin
      arready <= !(ar_take || (rvalid && !rready));
      if (ar_take) begin
        rvalid <= 1'h1;
        rdata  <= rd_mux;
        rresp  <= mapped(araddr) ? sfc_pkg::RESP_OKAY : sfc_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'h0;
      end
    end
  end

endmodule // sfc_fifo

`default_nettype wire

// File: pkg/sfc_pkg.sv
// Constants and types for the FIFO flag and cascade block.
// Assumes one clock (aclk, 100 MHz) and an AXI4-Lite register port.
//
// Summary of operation
// - Straps pick fall-through and almost-flag timing
// - Standard mode: shared pin is full flag
// - Fall-through: shared pin is input ready
// - Standard mode: shared pin is empty flag
// - Fall-through: shared pin is output ready
// - Almost-empty low within offset of empty
// - Almost-full low within offset of full
// - Half-full low above half depth
// - Cascade: pulse out when last location written
// - Cascade: pulse out when last location read
// - Read data bus is 18 bits wide
// - Reset clears pointers and sets flag values
// - Writes ignored while full
// - Reads ignored while empty
// - Fall-through first word after three edges
`default_nettype none

package sfc_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W    = 18;
  localparam int unsigned DEPTH_DEF = 256;
  localparam int unsigned OFF_W     = 12;
  localparam int unsigned FT_EDGES  = 3;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_LEVEL   = 8'h08;
  localparam logic [7:0] ADDR_AE_OFF  = 8'h0C;
  localparam logic [7:0] ADDR_AF_OFF  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h1C;
  localparam int unsigned CTRL_CASCADE = 0;
  localparam int unsigned STS_MODE_LSB = 5;
  localparam int unsigned STS_TOK_LSB  = 8;
  localparam int unsigned EV_FULL      = 0;
  localparam int unsigned EV_EMPTY     = 1;
  localparam int unsigned EV_WR_REFUSE = 2;
  localparam int unsigned EV_RD_REFUSE = 3;
  localparam int unsigned EV_W         = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cascade;
    logic fall_through_mode;
    logic sync_almost;
  } sfc_mode_t;

  typedef struct packed {
    logic half_full_n;
    logic almost_full_n;
    logic almost_empty_n;
    logic empty_n;
    logic full_n;
  } sfc_flags_t;

  localparam sfc_flags_t FLAGS_RST = '{half_full_n: 1'h1, almost_full_n: 1'h1,
                                       almost_empty_n: 1'h0, empty_n: 1'h0, full_n: 1'h1};

  // Offset after reset depends on array depth
  function automatic logic [OFF_W-1:0] default_offset(input int unsigned depth);
    if (depth <= 256) return 12'h01F;
    else if (depth <= 512) return 12'h03F;
    else return 12'h07F;
  endfunction

endpackage

`default_nettype wire

// File: verification/sfc_strap_model.sv
// Board-side model: strap jumpers and the idle neighbour of a chain.
// Assumes the bench picks the levels while the block is held in reset.
`default_nettype none

module sfc_strap_model (
  // Wanted levels: first load, write cascade, read cascade
  input  wire logic [2:0] strap_sel,
  // Pins toward the block
  output logic            first_load_strap,
  output logic            write_cascade_in,
  output logic            read_cascade_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Strap picks timing mode; low marks the first device of a chain
  assign first_load_strap = strap_sel[2];
  // Idle previous device holds its cascade outputs high, so no token
  assign write_cascade_in = strap_sel[1];
  assign read_cascade_in  = strap_sel[0];
endmodule // sfc_strap_model

`default_nettype wire

// File: verification/sfc_fifo_sva.sv
// Checker for flags, read data and the read cascade pulse of sfc_fifo.
// Assumes one clock; the level model holds in standard timing only.
`default_nettype none

module sfc_fifo_sva #(
  parameter int unsigned DEPTH  = 256,
  parameter int unsigned DATA_W = 18
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Stream
  input wire logic              wr_en,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] read_data_bus,
  // Straps
  input wire logic              first_load_strap,
  input wire logic              write_cascade_in,
  input wire logic              read_cascade_in,
  // Flags
  input wire logic              full_flag_n,
  input wire logic              empty_flag_n,
  input wire logic              almost_empty_n,
  input wire logic              almost_full_n,
  input wire logic              half_full_n,
  input wire logic              read_cascade_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DP   = DEPTH;
  localparam int AOFF = (DEPTH <= 256) ? 31 : ((DEPTH <= 512) ? 63 : 127);
  logic fall_through_mode_q;
  logic sync_q;
  int   cnt;

  // ------------------------------------------------------------
  // Mode capture and level model
  // ------------------------------------------------------------
  // Straps latched in reset, as the block does
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fall_through_mode_q <= first_load_strap;
      sync_q <= write_cascade_in & read_cascade_in;
    end
  end
  // Word count; meaningless in fall-through, so those checks are gated
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + int'(wr_en && cnt < DP) - int'(rd_en && cnt > 0);
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // No write for four edges, so nothing is already falling through
  sequence s_ft_idle;
    fall_through_mode_q && empty_flag_n && !$past(wr_en) && !$past(wr_en, 2)
      && !$past(wr_en, 3) && !$past(wr_en, 4);
  endsequence
  sequence s_ft_show;
    ##4 (read_data_bus == $past(wr_data, 4)) ##1 !empty_flag_n;
  endsequence

  a_reset_flags: assert property (disable iff (1'b0)
    !aresetn ##1 !aresetn |-> full_flag_n && almost_full_n && !empty_flag_n && !almost_empty_n)
    else $error("flags wrong during reset");
  a_empty_read_hold: assert property (
    !fall_through_mode_q && !empty_flag_n && rd_en && !$past(wr_en) |=> $stable(read_data_bus))
    else $error("read while empty changed the output word");
  a_ft_first_word: assert property (s_ft_idle ##0 wr_en |-> s_ft_show)
    else $error("fall-through first word late or wrong");
  a_std_full_flag: assert property (!fall_through_mode_q |-> full_flag_n == ($past(cnt) != DP))
    else $error("full flag disagrees with level");
  a_std_empty_flag: assert property (!fall_through_mode_q |-> empty_flag_n == ($past(cnt) != 0))
    else $error("empty flag disagrees with level");
  a_half_not_low: assert property (
    !fall_through_mode_q && $past(cnt) <= DP / 2 |-> half_full_n)
    else $error("half flag low at or below half");
  a_almost_empty: assert property (!fall_through_mode_q |->
    almost_empty_n == ((sync_q ? $past(cnt, 2) : $past(cnt)) > AOFF))
    else $error("almost-empty flag wrong");
  a_almost_full: assert property (!fall_through_mode_q |->
    almost_full_n == ((sync_q ? $past(cnt, 2) : $past(cnt)) < DP - AOFF))
    else $error("almost-full flag wrong");
  a_rd_pulse_one: assert property (!read_cascade_out |=> read_cascade_out)
    else $error("read cascade pulse longer than one cycle");
endmodule // sfc_fifo_sva

bind sfc_fifo sfc_fifo_sva #(.DEPTH(DEPTH), .DATA_W(DATA_W)) sfc_fifo_sva_inst (
  .aclk, .aresetn, .wr_en, .wr_data, .rd_en, .read_data_bus, .first_load_strap,
  .write_cascade_in, .read_cascade_in, .full_flag_n, .empty_flag_n, .almost_empty_n,
  .almost_full_n, .half_full_n, .read_cascade_out
);

`default_nettype wire

// File: verification/sfc_fifo_tb.sv
// Bench for sfc_fifo: standard, fall-through and cascade runs, registers.
// Assumes the bound checker and the strap model beside the block.
`default_nettype none

module sfc_fifo_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DP = 256;
  logic        aclk = 1'b0, aresetn = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [17:0] wr_data = 18'h00000, read_data_bus;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, d;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, read_cascade_out;
  logic        full_flag_n, empty_flag_n, almost_empty_n, almost_full_n, half_full_n;
  logic        first_load_strap, write_cascade_in, read_cascade_in;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  strap_sel = 3'h3;
  int          failures = 0, checks = 0, hf_lo = 0, rc_lo = 0;
  bit          mon_on = 1'b0;

  sfc_strap_model sfc_strap_model_inst (.strap_sel, .first_load_strap, .write_cascade_in,
    .read_cascade_in);
  sfc_fifo #(.DEPTH(DP)) sfc_fifo_inst (.aclk, .aresetn, .wr_en, .wr_data, .rd_en,
    .read_data_bus, .first_load_strap, .write_cascade_in, .read_cascade_in, .full_flag_n,
    .empty_flag_n, .almost_empty_n, .almost_full_n, .half_full_n, .read_cascade_out, .irq,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  // ------------------------------------------------------------
  // Clock, watchdog, pulse monitor
  // ------------------------------------------------------------
  initial forever #5 aclk = ~aclk;
  // Whole run is just over a thousand cycles; this is far beyond it
  initial begin
    #200000;
    failures++;
    complete_run();
  end
  // Counting low cycles catches both a missing and a stretched pulse
  always @(posedge aclk) begin
    if (mon_on) begin
      hf_lo <= hf_lo + int'(half_full_n === 1'b0);
      rc_lo <= rc_lo + int'(read_cascade_out === 1'b0);
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] s);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap_sel <= s;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // Address and data offered together, each dropped at its own handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    bit aw_done, w_done;
    int n;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 200);
    r = bresp;
    bready <= 1'b0;
    if (n >= 200) failures++;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 200) failures++;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    axi_rd(a);
    chk(nm, e, d);
  endtask
  // Back-to-back writes of 0..n-1; beyond DEPTH they must be dropped
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      wr_en <= 1'b1;
      wr_data <= 18'(i);
    end
    @(posedge aclk);
    wr_en <= 1'b0;
  endtask
  // Back-to-back reads, then one more edge with read held on empty
  task automatic drain(input int n);
    @(posedge aclk);
    rd_en <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      #1;
      chk("read word", 32'(i), 32'(read_data_bus));
    end
    @(posedge aclk);
    rd_en <= 1'b0;
    #1;
    chk("word after empty read", 32'(n - 1), 32'(read_data_bus));
  endtask
  function automatic logic [31:0] flags();
    return 32'({full_flag_n, empty_flag_n, almost_empty_n, almost_full_n, half_full_n});
  endfunction

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    // Read strap low selects asynchronous almost flags for this run
    do_reset(3'h2);
    #1;
    chk("flags in reset", 32'h13, flags());
    rd_chk(sfc_pkg::ADDR_STATUS, 32'h319, "status");
    rd_chk(sfc_pkg::ADDR_AE_OFF, 32'h1F, "ae offset");
    rd_chk(sfc_pkg::ADDR_AF_OFF, 32'h1F, "af offset");
    axi_rd(8'h20);
    chk("unmapped resp", 32'(sfc_pkg::RESP_SLVERR), 32'(r));
    axi_wr(sfc_pkg::ADDR_IRQ_CLR, 32'hF);
    axi_wr(sfc_pkg::ADDR_IRQ_EN, 32'h4);
    chk("write resp", 32'(sfc_pkg::RESP_OKAY), 32'(r));
    axi_wr(8'h22, 32'h1);
    chk("unmapped write resp", 32'(sfc_pkg::RESP_SLVERR), 32'(r));
    chk("irq idle", 32'h0, 32'(irq));
    fill(DP + 1);
    repeat (3) @(posedge aclk);
    #1;
    chk("flags full", 32'h0C, flags());
    chk("irq raised", 32'h1, 32'(irq));
    rd_chk(sfc_pkg::ADDR_LEVEL, 32'h100, "level");
    rd_chk(sfc_pkg::ADDR_IRQ_STS, 32'h5, "irq status");
    axi_wr(sfc_pkg::ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'h0, 32'(irq));
    axi_wr(sfc_pkg::ADDR_IRQ_CLR, 32'hF);
    rd_chk(sfc_pkg::ADDR_IRQ_STS, 32'h0, "irq cleared");
    drain(DP);
    repeat (3) @(posedge aclk);
    #1;
    chk("flags empty", 32'h13, flags());
    @(posedge aclk);
    rd_en <= 1'b1;
    @(posedge aclk);
    rd_en <= 1'b0;
    #1;
    chk("word kept on empty", 32'(DP - 1), 32'(read_data_bus));
    // Fall-through: one word, no read, appears by itself
    do_reset(3'h7);
    repeat (2) @(posedge aclk);
    @(posedge aclk);
    wr_en <= 1'b1;
    wr_data <= 18'h2A5A5;
    @(posedge aclk);
    wr_en <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    chk("ft word", 32'h2A5A5, 32'(read_data_bus));
    chk("ft ready flags", 32'h1, 32'({full_flag_n, empty_flag_n}));
    @(posedge aclk);
    #1;
    chk("ft output ready", 32'h0, 32'(empty_flag_n));
    @(posedge aclk);
    rd_en <= 1'b1;
    @(posedge aclk);
    rd_en <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    chk("ft drained", 32'h1, 32'(empty_flag_n));
    // Depth cascade: one pulse at last write and one at last read
    do_reset(3'h3);
    axi_wr(sfc_pkg::ADDR_CTRL, 32'h1);
    mon_on = 1'b1;
    fill(DP);
    repeat (4) @(posedge aclk);
    chk("write pulse count", 32'h1, 32'(hf_lo));
    drain(DP);
    repeat (4) @(posedge aclk);
    chk("read pulse count", 32'h1, 32'(rc_lo));
    complete_run();
  end
endmodule // sfc_fifo_tb

`default_nettype wire
